/* design/vsti_deser.sv */
/*
 * Diagnostic serial-to-parallel converter with a parallel buffer register.
 * Assumes one bit per clock while valid_i is high and first_i marking the
 * top bit of each column, all from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vsti_defs.svh"

module vsti_deser import vsti_pkg::*; #(
    parameter int SEG_BITS = `VSTI_SEG_BITS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Serial side
    input wire logic bit_i,
    input wire logic valid_i,
    input wire logic first_i,
    // Buffered word side
    output logic [SEG_BITS-1:0] word_o,
    output logic rdy_o
);
    logic [SEG_BITS-1:0] sh_reg; // Assembly shift register
    logic [3:0] cnt_reg; // Bits already taken in this segment
    logic [3:0] cur; // Position of the bit now arriving

    // A new column restarts the count so segments stay column aligned
    assign cur = first_i ? 4'h0 : cnt_reg;

    // Shift in, copy the full word into the buffer, flag it for one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sh_reg <= '0;
            cnt_reg <= 4'h0;
            word_o <= '0;
            rdy_o <= 1'h0;
        end else begin
            rdy_o <= 1'h0;
            if (valid_i) begin
                sh_reg <= {sh_reg[SEG_BITS-2:0], bit_i};
                if (cur == 4'(SEG_BITS - 1)) begin
                    // Top bit of the segment lands in the MSB
                    word_o <= {sh_reg[SEG_BITS-2:0], bit_i};
                    rdy_o <= 1'h1;
                    cnt_reg <= 4'h0;
                end else begin
                    cnt_reg <= cur + 4'h1;
                end
            end
        end
    end

    // Helper for the assertions: bits taken in a row since a column start.
    // Counting here keeps the property short instead of a long repetition.
    logic [3:0] run_cnt_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_cnt_reg <= 4'h0;
        end else if (first_i && valid_i) begin
            run_cnt_reg <= 4'h1;
        end else if (!valid_i) begin
            run_cnt_reg <= 4'h0;
        end else if (run_cnt_reg != 4'h0 && run_cnt_reg < 4'(SEG_BITS)) begin
            run_cnt_reg <= run_cnt_reg + 4'h1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Fourteenth bit of a column arriving: the first word is due
    sequence s_seg;
        valid_i && !first_i && run_cnt_reg == 4'(SEG_BITS - 1);
    endsequence

    word_seg_a: assert property (s_seg |=> rdy_o)
        else $error("segment did not complete after fourteen bits");
    word_gap_a: assert property (rdy_o |=> !rdy_o [*8])
        else $error("word ready pulses too close together");
endmodule
`default_nettype wire

/* design/vsti_top.sv */
/*
 * Serial video path: scrubber, load register, vertical thickener,
 * 15 x 56 image register with parallel match taps, and a diagnostic
 * word readout, all behind a classic Wishbone register slave.
 * Assumes the accumulator column and the Wishbone master share clk_i;
 * the maintenance switches are asynchronous pins.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vsti_defs.svh"

// Functional notes
// - Scrub black runs touching window edge
// - Thickener slides three-bit window per shift
// - White-black-white turns bottom bit black
// - Normal feed enters column one bottom
// - Mirror mode feeds column fifteen, reversed
// - Image register is 15 by 56
// - Column top feeds neighbour column bottom
// - Upper 24 rows presented in parallel
// - Images shift through every stage
// - Switch routes thickener to host
// - Column read as four 14-bit segments
// - Converter taps column fifteen, load or thickener
// - Words copied to buffer host samples
// - Program with switches, or switches alone
// - Load register shifts out top, fills zero
// - New column every 60 shift clocks
module vsti_top import vsti_pkg::*; #(
    parameter int COL_BITS = `VSTI_COL_BITS,
    parameter int COLS = `VSTI_COLS,
    parameter int ROWS = `VSTI_MATCH_ROWS,
    parameter int SEG_BITS = `VSTI_SEG_BITS,
    parameter int PERIOD = `VSTI_LOAD_PERIOD,
    parameter bit MIRROR_FITTED = 1'h1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:2] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Accumulator column, 0 = black
    input wire logic [COL_BITS-1:0] opt_col_i,
    // Maintenance panel switches
    input wire logic sw_prog_i,
    input wire logic sw_sim_i,
    input wire logic sw_ltr_i,
    input wire logic sw_img_off_i,
    input wire logic [1:0] sw_src_i,
    // Recognition taps
    output logic [ROWS*COLS-1:0] match_o,
    // Diagnostic words
    output logic [SEG_BITS-1:0] diag_word_o,
    output logic diag_rdy_o
);
    localparam int TOP = COL_BITS - 1;

    // Register state
    logic [`VSTI_CTRL_W-1:0] ctrl_reg; // Program control word
    logic [COL_BITS-1:0] sim_col_reg; // Simulated column
    logic rdy_flag_reg; // Unread word present
    logic ovr_flag_reg; // Word replaced before read
    logic ack_reg; // Bus acknowledge
    logic [31:0] dat_reg; // Bus read data

    // Switch synchronisers; stage one feeds stage two only
    logic [5:0] sw_meta_reg;
    logic [5:0] sw_sync_reg;

    // Video path state
    logic [5:0] phase_reg; // Position within the load period
    logic [COL_BITS-1:0] load_reg; // Load register, 1 = black
    logic [1:0] win_reg; // Older two bits of the window
    logic [COL_BITS-1:0] img_reg [COLS]; // Image columns

    // Combinational helpers
    logic [`VSTI_CTRL_W-1:0] eff; // Controls in force
    logic ltr; // Reverse shift in force
    logic img_en; // Image register takes data
    vsti_src_t src; // Diagnostic tap
    logic ld; // Column load strobe
    logic cur; // Bit leaving the load register
    logic thick_bit; // Thickener output
    logic diag_bit; // Converter input
    logic acc; // Bus access taken this edge
    logic data_rd; // Read of the word register
    logic [COL_BITS-1:0] blk; // Column with 1 = black
    wire [COL_BITS-1:0] run_top; // Black run from the top edge
    wire [COL_BITS-1:0] run_bot; // Black run from the bottom edge
    wire [COLS+1:0] tops_w; // Column tops with feed at both ends

    // Bring the panel switches into the clock domain
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw_meta_reg <= '0;
            sw_sync_reg <= '0;
        end else begin
            sw_meta_reg <= {sw_prog_i, sw_src_i, sw_img_off_i, sw_ltr_i, sw_sim_i};
            sw_sync_reg <= sw_meta_reg;
        end
    end

    // Program bits apply only while the panel allows it
    always_comb begin
        if (sw_sync_reg[5]) begin
            eff = ctrl_reg;
        end else begin
            eff = sw_sync_reg[4:0];
        end
    end

    // Without the mirror option the reverse control has no effect
    assign ltr = MIRROR_FITTED && eff[`VSTI_CTRL_LTR];
    assign img_en = !eff[`VSTI_CTRL_IMGOFF];
    assign src = vsti_src_t'(eff[`VSTI_CTRL_SRC_LO +: 2]);

    // Load period counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_reg <= 6'h00;
        end else if (phase_reg == 6'(PERIOD - 1)) begin
            phase_reg <= 6'h00;
        end else begin
            phase_reg <= phase_reg + 6'h01;
        end
    end

    assign ld = (phase_reg == 6'(PERIOD - 1));

    // Invert so that black is 1 from here on and zero fill is white
    assign blk = eff[`VSTI_CTRL_SIM] ? ~sim_col_reg : ~opt_col_i;

    // Black runs connected to either window edge
    for (genvar i = 0; i < COL_BITS; i++) begin : g_run
        if (i == TOP) begin : g_t
            assign run_top[i] = blk[i];
        end else begin : g_tn
            assign run_top[i] = blk[i] & run_top[i+1];
        end
        if (i == 0) begin : g_b
            assign run_bot[i] = blk[i];
        end else begin : g_bn
            assign run_bot[i] = blk[i] & run_bot[i-1];
        end
    end

    // Whole column is held, scrubbed as a unit, then shifted out top first.
    // Holding a full column costs 56 flops but lets runs from both edges
    // be seen before any of their bits leave.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            load_reg <= '0;
        end else if (ld) begin
            load_reg <= blk & ~run_top & ~run_bot;
        end else begin
            load_reg <= {load_reg[TOP-1:0], 1'h0};
        end
    end

    assign cur = load_reg[TOP];

    // Sliding window: win_reg[1] first, win_reg[0] second, cur third
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            win_reg <= 2'h0;
        end else begin
            win_reg <= {win_reg[0], cur};
        end
    end

    // A lone black bit blackens the bit below it
    assign thick_bit = cur | (!win_reg[1] & win_reg[0]);

    // Column tops, with the feed bit at each end of the chain
    assign tops_w[0] = thick_bit;
    assign tops_w[COLS+1] = thick_bit;
    for (genvar c = 0; c < COLS; c++) begin : g_top
        assign tops_w[c+1] = img_reg[c][TOP];
    end

    // Image columns; index 0 is column 1, the right-most.
    // Holding the array while routed to the host only freezes the image.
    for (genvar c = 0; c < COLS; c++) begin : g_col
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                img_reg[c] <= '0;
            end else if (img_en) begin
                if (ltr) begin
                    // Reverse chain, fed at column 15
                    img_reg[c] <= {img_reg[c][TOP-1:0], tops_w[c+2]};
                end else begin
                    // Normal chain, fed at column 1
                    img_reg[c] <= {img_reg[c][TOP-1:0], tops_w[c]};
                end
            end
        end
        // Upper rows of each column drive the matrices
        for (genvar r = 0; r < ROWS; r++) begin : g_row
            assign match_o[c*ROWS+r] = img_reg[c][COL_BITS-ROWS+r];
        end
    end

    // Diagnostic tap selection
    always_comb begin
        case (src)
            VSTI_SRC_LOAD: diag_bit = cur;
            VSTI_SRC_THICK: diag_bit = thick_bit;
            default: diag_bit = img_reg[COLS-1][TOP];
        endcase
    end

    // Segments aligned to the 56 data slots of each load period.
    // The image tap lines up too because 840 shifts is 14 periods,
    // but only on the normal chain and while the array shifts without pause.
    vsti_deser #(
        .SEG_BITS(SEG_BITS)
    ) u_deser (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .bit_i(diag_bit),
        .valid_i(phase_reg < 6'(COL_BITS)),
        .first_i(phase_reg == 6'h00),
        .word_o(diag_word_o),
        .rdy_o(diag_rdy_o)
    );

    // Bus access is taken on the edge that raises ack
    assign acc = wb_cyc_i && wb_stb_i && !ack_reg;
    assign data_rd = acc && !wb_we_i && (wb_adr_i == `VSTI_ADR_DATA);

    // Acknowledge one cycle after the request, dropped the next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'h0;
        end else begin
            ack_reg <= acc;
        end
    end

    assign wb_ack_o = ack_reg;

    // Writable registers, honouring byte selects
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `VSTI_CTRL_RST;
            sim_col_reg <= '1;
        end else if (acc && wb_we_i) begin
            case (wb_adr_i)
                `VSTI_ADR_CTRL: begin
                    if (wb_sel_i[0]) begin
                        ctrl_reg <= wb_dat_i[`VSTI_CTRL_W-1:0];
                    end
                end
                `VSTI_ADR_SIMLO: begin
                    for (int b = 0; b < 4; b++) begin
                        if (wb_sel_i[b]) begin
                            sim_col_reg[8*b +: 8] <= wb_dat_i[8*b +: 8];
                        end
                    end
                end
                `VSTI_ADR_SIMHI: begin
                    for (int b = 0; b < 3; b++) begin
                        if (wb_sel_i[b]) begin
                            sim_col_reg[32+8*b +: 8] <= wb_dat_i[8*b +: 8];
                        end
                    end
                end
                default: begin
                    // Read-only or unmapped: write ignored
                end
            endcase
        end
    end

    // Ready flag: a new word wins over a clearing read in the same cycle; overrun is cleared by that read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdy_flag_reg <= 1'h0;
            ovr_flag_reg <= 1'h0;
        end else begin
            if (diag_rdy_o) begin
                rdy_flag_reg <= 1'h1;
            end else if (data_rd) begin
                rdy_flag_reg <= 1'h0;
            end
            if (diag_rdy_o && rdy_flag_reg && !data_rd) begin
                ovr_flag_reg <= 1'h1;
            end else if (data_rd) begin
                ovr_flag_reg <= 1'h0;
            end
        end
    end

    // Read data, captured with the access; unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 32'h0;
        end else if (acc && !wb_we_i) begin
            case (wb_adr_i)
                `VSTI_ADR_CTRL: dat_reg <= 32'(ctrl_reg);
                `VSTI_ADR_STAT: dat_reg <= 32'({eff, phase_reg, ovr_flag_reg, rdy_flag_reg});
                `VSTI_ADR_DATA: dat_reg <= 32'(diag_word_o);
                `VSTI_ADR_SIMLO: dat_reg <= sim_col_reg[31:0];
                `VSTI_ADR_SIMHI: dat_reg <= 32'(sim_col_reg[COL_BITS-1:32]);
                default: dat_reg <= 32'h0;
            endcase
        end
    end

    assign wb_dat_o = dat_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Window holding white then black
    sequence s_wtw;
        !win_reg[1] && win_reg[0];
    endsequence

    // Normal shifting with the image register enabled
    sequence s_norm;
        img_en && !ltr;
    endsequence

    scrub_edge_a: assert property (ld |=> !load_reg[TOP] && !load_reg[0])
        else $error("black bit at window edge survived scrubbing");
    thick_fill_a: assert property (s_wtw |-> thick_bit)
        else $error("white-black-white not thickened");
    thick_pass_a: assert property (!win_reg[0] && !cur |-> !thick_bit)
        else $error("thickener blackened a white bit");
    load_period_a: assert property (ld |-> ##60 ld)
        else $error("column load period is not 60 clocks");
    load_empty_a: assert property (ld |-> ##57 (load_reg == '0))
        else $error("load register not empty after 56 shifts");
    feed_norm_a: assert property (s_norm |=> img_reg[0][0] == $past(thick_bit))
        else $error("thickener output missing at column 1 bottom");
    feed_mirror_a: assert property (img_en && ltr
        |=> img_reg[COLS-1][0] == $past(thick_bit))
        else $error("thickener output missing at column 15 bottom");
    chain_left_a: assert property (s_norm |=> img_reg[1][0] == $past(img_reg[0][TOP]))
        else $error("column 1 top did not reach column 2 bottom");
    diag_src_a: assert property (src == VSTI_SRC_LOAD && phase_reg == 6'(SEG_BITS - 1)
        |=> diag_word_o[0] == $past(load_reg[TOP]))
        else $error("converter not fed from load register top");
    rdy_flag_a: assert property (diag_rdy_o |=> rdy_flag_reg)
        else $error("new word did not set the ready flag");
endmodule
`default_nettype wire

/* inc/vsti_defs.svh */
/*
 * Constants of the video scrub, thicken and image register block:
 * geometry, timing counts, register word indices and control fields.
 * Assumes nothing; included by its bare name from the modules, not from the package.
 */
`ifndef VSTI_DEFS_SVH
`define VSTI_DEFS_SVH

// Column geometry and image array shape
`define VSTI_COL_BITS 56
`define VSTI_COLS 15
`define VSTI_MATCH_ROWS 24
`define VSTI_SEG_BITS 14

// Shift clocks between two parallel column loads
`define VSTI_LOAD_PERIOD 60

// Register word indices (byte address = 4 x index)
`define VSTI_ADR_CTRL 3'h0
`define VSTI_ADR_STAT 3'h1
`define VSTI_ADR_DATA 3'h2
`define VSTI_ADR_SIMLO 3'h3
`define VSTI_ADR_SIMHI 3'h4

// Control register fields and reset value
`define VSTI_CTRL_W 5
`define VSTI_CTRL_SIM 0
`define VSTI_CTRL_LTR 1
`define VSTI_CTRL_IMGOFF 2
`define VSTI_CTRL_SRC_LO 3
`define VSTI_CTRL_RST 5'h00

`endif

/* inc/vsti_pkg.sv */
/*
 * Types shared by the video scrub, thicken and image register block.
 * Assumes vsti_defs.svh for numeric constants.
 */
package vsti_pkg;
    // Diagnostic readout point for the serial-to-parallel converter
    typedef enum logic [1:0] {
        VSTI_SRC_IMAGE,
        VSTI_SRC_LOAD,
        VSTI_SRC_THICK
    } vsti_src_t;
endpackage

/* sim/test_video_scrub_thicken_image_register.sv */
/*
 * Self-checking bench: Wishbone register access, diagnostic readout of
 * scrubbed columns from the load register tap, and recognition taps.
 * Assumes the host model above and the hand-over timing of the block.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vsti_defs.svh"

module test_video_scrub_thicken_image_register;
    import vsti_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [4:2] wb_adr_i = 3'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o;
    logic [55:0] opt_col_i = 56'hFF_FFFF_FFFF_FFFF; // Idle input is white
    logic sw_prog_i = 1'b0, sw_sim_i = 1'b0, sw_ltr_i = 1'b0, sw_img_off_i = 1'b0;
    logic [1:0] sw_src_i = 2'h0;
    logic [359:0] match_o;
    logic [13:0] diag_word_o;
    logic diag_rdy_o;
    int errors = 0;
    int checks_done = 0;
    int seed = 32'h1d884d9f;
    logic [55:0] col;
    logic [359:0] held; // Taps seen once the image froze

    vsti_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .opt_col_i(opt_col_i),
        .sw_prog_i(sw_prog_i), .sw_sim_i(sw_sim_i), .sw_ltr_i(sw_ltr_i),
        .sw_img_off_i(sw_img_off_i), .sw_src_i(sw_src_i), .match_o(match_o),
        .diag_word_o(diag_word_o), .diag_rdy_o(diag_rdy_o));
    vsti_host_model i_host (.clk_i(clk_i), .word_i(diag_word_o), .rdy_i(diag_rdy_o));

    // 200 MHz clock
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    // Single compare point; four-state equality so unknowns never match
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Classic Wishbone cycle: hold everything until ack is sampled high
    task automatic wb(input logic we, input logic [2:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) check("wb ack", 32'h0, 32'h1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // Reference: invert to black = 1, then clear runs touching either edge
    function automatic logic [55:0] scrub(input logic [55:0] raw);
        logic [55:0] b;
        b = ~raw;
        for (int i = 55; i >= 0 && b[i]; i--) b[i] = 1'b0;
        for (int i = 0; i < 56 && b[i]; i++) b[i] = 1'b0;
        return b;
    endfunction

    // Collect words of a steady column; word 0 is the one after the long gap
    task automatic check_column(input logic [55:0] raw, input bit thick);
        logic [55:0] b;
        int j, n;
        b = scrub(raw);
        // Window of scrubbed bits: a lone black above a white blackens that white
        if (thick) b = b | ((b >> 1) & ~(b >> 2));
        repeat (130) @(posedge clk_i);
        i_host.words.delete();
        i_host.stamps.delete();
        n = 0;
        while (i_host.words.size() < 12 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        j = 1;
        while (j < 5 && i_host.stamps[j] - i_host.stamps[j-1] != 18) j++;
        check("column gap", i_host.stamps[j] - i_host.stamps[j-1], 18);
        for (int k = 0; k < 4; k++) begin
            check("diag word", i_host.words[j+k], b[55-14*k -: 14]);
            if (k > 0) check("word gap", i_host.stamps[j+k] - i_host.stamps[j+k-1], 14);
        end
        // Many unread words: ready and overrun both stand until the read
        wb(1'b0, `VSTI_ADR_STAT, 32'h0);
        check("word flags", {30'h0, rd[1:0]}, 32'h3);
        wb(1'b0, `VSTI_ADR_DATA, 32'h0);
        check("data reg", rd, 32'(b[55-14*((11-j)%4) -: 14]));
        wb(1'b0, `VSTI_ADR_STAT, 32'h0);
        check("flags cleared", {30'h0, rd[1:0]}, 32'h0);
    endtask

    // Wait a bounded time for a black point; it must first show at row 0 of column c
    task automatic expect_match(input int c);
        int n;
        n = 0;
        while (match_o === '0 && n < 1000) begin
            @(posedge clk_i);
            n++;
        end
        check("match taps", match_o === (360'h1 << (24 * c)), 32'h1);
    endtask

    // Watchdog sized well above the sequence length
    initial begin
        repeat (60000) @(posedge clk_i);
        errors++;
        complete_run();
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("match reset", match_o === '0, 32'h1);
        wb(1'b0, `VSTI_ADR_CTRL, 32'h0);
        check("ctrl reset", rd, 32'h0);
        wb(1'b0, 3'h5, 32'h0);
        check("unmapped read", rd, 32'h0);
        wb(1'b1, `VSTI_ADR_CTRL, 32'hFFFF_FFFF);
        wb(1'b0, `VSTI_ADR_CTRL, 32'h0);
        check("ctrl width", rd, 32'h1F);
        // Program control: simulated column, load register tap
        sw_prog_i <= 1'b1;
        wb(1'b1, `VSTI_ADR_CTRL, 32'h09);
        for (int t = 0; t < 4; t++) begin
            col = 56'({$random(seed), $random(seed)});
            if (t == 0) col = 56'h03_FFFF_F00F_FFF0; // Edge runs and a middle run
            wb(1'b1, `VSTI_ADR_SIMLO, col[31:0]);
            wb(1'b1, `VSTI_ADR_SIMHI, {8'h0, col[55:32]});
            check_column(col, 1'b0);
        end
        // Switches alone; program bits disagree and must not count
        wb(1'b1, `VSTI_ADR_CTRL, 32'h0);
        sw_prog_i <= 1'b0;
        sw_sim_i <= 1'b1;
        sw_src_i <= 2'h1;
        check_column(col, 1'b0);
        sw_sim_i <= 1'b0;
        opt_col_i <= 56'({$random(seed), $random(seed)});
        @(posedge clk_i);
        check_column(opt_col_i, 1'b0);
        // Thickener output to the host only; the image must hold still
        sw_sim_i <= 1'b1;
        sw_src_i <= 2'h2;
        sw_img_off_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        held = match_o;
        check_column(col, 1'b1);
        check("image frozen", match_o === held, 32'h1);
        // One black point mid-column from an empty image, normal then mirror
        sw_img_off_i <= 1'b0;
        sw_src_i <= 2'h0;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("match cleared", match_o === '0, 32'h1);
        wb(1'b1, `VSTI_ADR_SIMLO, 32'hBFFF_FFFF);
        expect_match(0);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        sw_ltr_i <= 1'b1;
        wb(1'b1, `VSTI_ADR_SIMLO, 32'hBFFF_FFFF);
        expect_match(`VSTI_COLS - 1);
        complete_run();
    end
endmodule
`default_nettype wire

/* sim/vsti_host_model.sv */
/*
 * Host controller side model: samples the diagnostic buffer register
 * whenever the word-ready strobe stands and keeps word and cycle stamp.
 * Assumes the strobe is a one-cycle pulse on the shared clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vsti_defs.svh"

module vsti_host_model #(
    parameter int SEG_BITS = `VSTI_SEG_BITS
) (
    // Clock
    input wire logic clk_i,
    // Buffered word from the block
    input wire logic [SEG_BITS-1:0] word_i,
    input wire logic rdy_i
);
    int cycle = 0; // Free-running cycle stamp
    logic [SEG_BITS-1:0] words[$]; // Words in arrival order
    int stamps[$]; // Cycle of each arrival

    // Sample in the only cycle the strobe stands, never later
    always @(posedge clk_i) begin
        cycle <= cycle + 1;
        if (rdy_i === 1'b1) begin
            words.push_back(word_i);
            stamps.push_back(cycle);
        end
    end
endmodule
`default_nettype wire
